// ---- can_fault_pkg.sv ----
// constants and carrier types for the fault confinement and mask block
package can_fault_pkg;
  localparam logic [7:0]  ADDR_CONFIG     = 8'h00;
  localparam logic [7:0]  ADDR_GMASK      = 8'h10;
  localparam logic [7:0]  ADDR_MASK14     = 8'h14;
  localparam logic [7:0]  ADDR_MASK15     = 8'h18;
  localparam logic [7:0]  ADDR_ECR        = 8'h1C;
  localparam logic [7:0]  ADDR_ESR        = 8'h20;
  localparam logic [7:0]  ADDR_IMASK2     = 8'h24;
  localparam logic [31:0] MASK_RESET      = 32'hFFFFFFFF;
  localparam logic [31:0] IMASK2_RESET    = 32'h00000000;
  localparam logic [31:0] ID_FIELD        = 32'h1FFFFFFF;
  // config bit positions
  localparam int CFG_INDIV  = 0;
  localparam int CFG_QUEUE  = 1;
  localparam int CFG_WARNING_ENABLE  = 2;
  localparam int CFG_FREEZE = 3;
  localparam int CFG_LISTEN = 4;
  localparam int CFG_TWMSK  = 5;
  localparam int CFG_RWMSK  = 6;
  localparam int CFG_BOMSK  = 7;
  localparam int CFG_ERMSK  = 8;
  localparam int CFG_WIDTH  = 9;
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 9'h000;
  // status register bit positions
  localparam int ESR_TWINT = 17;
  localparam int ESR_RWINT = 16;
  localparam int ESR_ERR_HI = 15;
  localparam int ESR_ERR_LO = 10;
  localparam int ESR_TX_WARNING_STATUS = 9;
  localparam int ESR_RX_WARNING_STATUS = 8;
  localparam int ESR_IDLE  = 7;
  localparam int ESR_DIR   = 6;
  localparam int ESR_FLT_HI = 5;
  localparam int ESR_FLT_LO = 4;
  localparam int ESR_BOINT = 2;
  localparam int ESR_ERINT = 1;
  localparam int ECR_TX_LO = 8;
  // fault state field encodings
  localparam logic [1:0] FLT_ACTIVE  = 2'h0;
  localparam logic [1:0] FLT_PASSIVE = 2'h1;
  localparam logic [1:0] FLT_BUSOFF  = 2'h2;
  // counter thresholds
  localparam logic [7:0] WARN_LEVEL    = 8'h60;
  localparam logic [8:0] TX_MAX        = 9'h0FF;
  localparam logic [7:0] TX_ERR_STEP   = 8'h08;
  localparam logic [7:0] RX_ERR_STEP   = 8'h08;
  localparam logic [7:0] RX_RESUME     = 8'h77;
  localparam logic [7:0] BOFF_RUNS     = 8'h80;
  localparam logic [3:0] BOFF_RUN_BITS = 4'hB;
  localparam logic [5:0] BUF_14        = 6'h0E;
  localparam logic [5:0] BUF_15        = 6'h0F;
  localparam logic [5:0] ELEM_6        = 6'h06;
  localparam logic [5:0] ELEM_7        = 6'h07;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {st_active, st_passive, st_busoff} fault_type;
  // order matches status bits 15..10
  typedef struct packed {
    logic recessive_bit;
    logic dominant_bit;
    logic ack;
    logic crc;
    logic form;
    logic stuff;
  } err_ev_type;
  typedef struct packed {
    logic tx_err;
    logic rx_err1;
    logic rx_err8;
    logic tx_ok;
    logic rx_ok;
  } cnt_ev_type;
  typedef struct packed {
    logic own_tx;
    logic in_arbitration;
    logic in_ack_slot;
    logic passive_flag;
  } bit_ctx_type;
endpackage

// ---- can_fault_confinement_and_masks.sv ----
// CAN fault confinement, error status and acceptance masks with AXI4-Lite registers
// Overview of operation
// - mask 0 ignores bit, 1 compares it
// - buffer-14 mask covers buffer 14, element 6
// - buffer-15 mask covers buffer 15, element 7
// - individual masking disables the three masks
// - two 8-bit counters, writable only frozen
// - counter writes pass holding register handshake
// - any counter at 128 gives error passive
// - both counters below 128 return active
// - transmit overflow past 255 gives bus off
// - bus off counts 128 runs of 11
// - passive node skips acknowledge error increments
// - receive count freezes above 127, resumes 119
// - error bits accumulate, status read clears
// - four flags clear by writing one
// - warning flags set on rise to 96
// - recessive-bit error excludes arbitration, ack, passive flag
// - dominant-bit error during own transmission
// - only transmitter flags ack errors; checksum, form, stuffing errors always flag
// - idle and direction status bits
// - fault field encoding, listen-only, soft reset
// - bus-off and error summary flags request interrupts
// - warning masks inert and zero without enable
`timescale 1ns/1ps
module can_fault_confinement_and_masks (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     bit_tick,
  input  wire logic                     rx_bit,
  input  wire logic                     bus_idle,
  input  wire logic                     transmitting,
  input  wire logic                     soft_rst,
  input  wire can_fault_pkg::err_ev_type err_ev,
  input  wire can_fault_pkg::cnt_ev_type cnt_ev,
  input  wire can_fault_pkg::bit_ctx_type bit_ctx,
  input  wire logic [5:0]               filt_index,
  input  wire logic                     filt_is_queue,
  input  wire logic [31:0]              filt_word,
  input  wire logic [31:0]              filt_rx_word,
  input  wire logic [31:0]              filt_indiv_mask,
  output logic                          filt_match_ff,
  output logic                          irq_tx_warning,
  output logic                          irq_rx_warning,
  output logic                          irq_bus_off,
  output logic                          irq_error
);
  logic [can_fault_pkg::CFG_WIDTH-1:0] cfg_ff;
  logic [31:0]                         gmask_ff;
  logic [31:0]                         mask14_ff;
  logic [31:0]                         mask15_ff;
  logic [31:0]                         imask2_ff;
  logic [7:0]                          tx_cnt_ff;
  logic [7:0]                          rx_cnt_ff;
  logic [7:0]                          nxt_tx_cnt;
  logic [7:0]                          nxt_rx_cnt;
  logic [3:0]                          rec_ff;
  logic [3:0]                          nxt_rec;
  logic [15:0]                         ecr_hold_ff;
  logic                                ecr_req_ff;
  can_fault_pkg::fault_type            state_ff;
  can_fault_pkg::fault_type            nxt_state;
  can_fault_pkg::err_ev_type           err_flags_ff;
  can_fault_pkg::err_ev_type           err_eff;
  logic                                tx_warn_flag_ff;
  logic                                rx_warn_flag_ff;
  logic                                busoff_flag_ff;
  logic                                err_sum_flag_ff;
  logic                                tx_warn_prev_ff;
  logic                                rx_warn_prev_ff;
  logic                                tx_warning_status;
  logic                                rx_warning_status;
  logic                                wr_fire;
  logic                                rd_fire;
  logic                                esr_read;
  logic                                ecr_load;
  logic [31:0]                         wmask;
  logic [31:0]                         esr_value;
  logic [31:0]                         rd_value;
  logic                                rd_hit;
  logic                                wr_hit;
  logic [1:0]                          flt_field;
  logic [8:0]                          tx_sum;
  logic [7:0]                          tx_add;
  logic [7:0]                          rx_add;

  // byte strobes to a bit mask
  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return a == can_fault_pkg::ADDR_CONFIG || a == can_fault_pkg::ADDR_GMASK ||
           a == can_fault_pkg::ADDR_MASK14 || a == can_fault_pkg::ADDR_MASK15 ||
           a == can_fault_pkg::ADDR_ECR || a == can_fault_pkg::ADDR_ESR ||
           a == can_fault_pkg::ADDR_IMASK2;
  endfunction

  // bus handshakes: write address and data are taken together
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && !s_axi_rvalid;
  assign wmask         = strobe_mask(s_axi_wstrb);
  assign wr_hit        = addr_mapped(s_axi_awaddr);
  assign rd_hit        = addr_mapped(s_axi_araddr);
  assign esr_read      = rd_fire && s_axi_araddr == can_fault_pkg::ADDR_ESR;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= can_fault_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? can_fault_pkg::RESP_OKAY : can_fault_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= can_fault_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_hit ? can_fault_pkg::RESP_OKAY : can_fault_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // configuration and mask registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_ff    <= can_fault_pkg::CFG_RESET;
      gmask_ff  <= can_fault_pkg::MASK_RESET;
      mask14_ff <= can_fault_pkg::MASK_RESET;
      mask15_ff <= can_fault_pkg::MASK_RESET;
      imask2_ff <= can_fault_pkg::IMASK2_RESET;
    end else if (wr_fire) begin
      unique case (s_axi_awaddr)
        can_fault_pkg::ADDR_CONFIG: begin
          cfg_ff <= (cfg_ff & ~wmask[can_fault_pkg::CFG_WIDTH-1:0]) |
                    (s_axi_wdata[can_fault_pkg::CFG_WIDTH-1:0] &
                     wmask[can_fault_pkg::CFG_WIDTH-1:0]);
        end
        can_fault_pkg::ADDR_GMASK:  gmask_ff  <= (gmask_ff & ~wmask) | (s_axi_wdata & wmask);
        can_fault_pkg::ADDR_MASK14: mask14_ff <= (mask14_ff & ~wmask) | (s_axi_wdata & wmask);
        can_fault_pkg::ADDR_MASK15: mask15_ff <= (mask15_ff & ~wmask) | (s_axi_wdata & wmask);
        can_fault_pkg::ADDR_IMASK2: imask2_ff <= (imask2_ff & ~wmask) | (s_axi_wdata & wmask);
        default: ;
      endcase
    end
  end

  // acceptance filter compare, answer one cycle later
  function automatic logic [31:0] pick_mask(input logic [5:0] idx, input logic is_queue,
                                            input logic queue_on, input logic [31:0] g,
                                            input logic [31:0] m14, input logic [31:0] m15);
    logic [31:0] m;
    m = g;
    if (is_queue && queue_on) begin
      if (idx == can_fault_pkg::ELEM_6) m = m14;
      if (idx == can_fault_pkg::ELEM_7) m = m15;
    end else begin
      if (idx == can_fault_pkg::BUF_14) m = m14;
      if (idx == can_fault_pkg::BUF_15) m = m15;
      // buffers mask identifier bits only
      m = m & can_fault_pkg::ID_FIELD;
    end
    return m;
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      filt_match_ff <= 1'b0;
    end else begin
      // zero bits ignored, individual masks replace ours
      filt_match_ff <= ~|((filt_word ^ filt_rx_word) &
                          (cfg_ff[can_fault_pkg::CFG_INDIV] ? filt_indiv_mask :
                           pick_mask(filt_index, filt_is_queue, cfg_ff[can_fault_pkg::CFG_QUEUE],
                                     gmask_ff, mask14_ff, mask15_ff)));
    end
  end

  // qualified error events
  always_comb begin
    err_eff = err_ev;
    err_eff.recessive_bit = err_ev.recessive_bit && !(bit_ctx.own_tx &&
                            (bit_ctx.in_arbitration || bit_ctx.in_ack_slot ||
                             bit_ctx.passive_flag));
    err_eff.dominant_bit = err_ev.dominant_bit && bit_ctx.own_tx;
    err_eff.ack          = err_ev.ack && bit_ctx.own_tx;
  end

  // counter writes are accepted only in freeze mode
  always_ff @(posedge clk) begin
    if (rst) begin
      ecr_hold_ff <= 16'h0000;
      ecr_req_ff  <= 1'b0;
    end else if (wr_fire && s_axi_awaddr == can_fault_pkg::ADDR_ECR &&
                 cfg_ff[can_fault_pkg::CFG_FREEZE]) begin
      // park the value, raise the request
      ecr_hold_ff <= (ecr_hold_ff & ~wmask[15:0]) | (s_axi_wdata[15:0] & wmask[15:0]);
      ecr_req_ff  <= 1'b1;
    end else if (ecr_load) begin
      ecr_req_ff <= 1'b0;
    end
  end

  // bit side acknowledges on its next bit time
  assign ecr_load = ecr_req_ff && bit_tick;

  always_comb begin
    nxt_tx_cnt = tx_cnt_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rec    = rec_ff;
    nxt_state  = state_ff;
    tx_add = (cnt_ev.tx_err || (err_eff.ack && state_ff != can_fault_pkg::st_passive)) ?
             can_fault_pkg::TX_ERR_STEP : 8'h00;
    rx_add = cnt_ev.rx_err8 ? can_fault_pkg::RX_ERR_STEP : {7'h00, cnt_ev.rx_err1};
    tx_sum = {1'b0, tx_cnt_ff} + {1'b0, tx_add};
    if (ecr_load) begin
      nxt_tx_cnt = ecr_hold_ff[15:8];
      nxt_rx_cnt = ecr_hold_ff[7:0];
    end else if (state_ff == can_fault_pkg::st_busoff) begin
      if (bit_tick) begin
        if (!rx_bit) begin
          nxt_rec = 4'h0;
        end else if (rec_ff == can_fault_pkg::BOFF_RUN_BITS - 4'h1) begin
          nxt_rec    = 4'h0;
          nxt_tx_cnt = tx_cnt_ff + 8'h01;
          if (nxt_tx_cnt == can_fault_pkg::BOFF_RUNS) begin
            nxt_state  = can_fault_pkg::st_active;
            nxt_tx_cnt = 8'h00;
            nxt_rx_cnt = 8'h00;
          end
        end else begin
          nxt_rec = rec_ff + 4'h1;
        end
      end
    end else begin
      if (tx_sum > can_fault_pkg::TX_MAX) begin
        // overflow enters bus off and clears the count
        nxt_state  = can_fault_pkg::st_busoff;
        nxt_tx_cnt = 8'h00;
        nxt_rec    = 4'h0;
      end else if (cnt_ev.tx_ok && tx_add == 8'h00 && tx_cnt_ff != 8'h00) begin
        nxt_tx_cnt = tx_cnt_ff - 8'h01;
      end else begin
        nxt_tx_cnt = tx_sum[7:0];
      end
      // stall above 127, resume value on good reception
      if (cnt_ev.rx_ok) begin
        if (rx_cnt_ff[7]) begin
          nxt_rx_cnt = can_fault_pkg::RX_RESUME;
        end else if (rx_cnt_ff != 8'h00) begin
          nxt_rx_cnt = rx_cnt_ff - 8'h01;
        end
      end else if (!rx_cnt_ff[7]) begin
        nxt_rx_cnt = rx_cnt_ff + rx_add;
      end
      if (nxt_state != can_fault_pkg::st_busoff) begin
        // passive at 128 or more, active when both below
        nxt_state = (nxt_tx_cnt[7] || nxt_rx_cnt[7]) ? can_fault_pkg::st_passive :
                                                       can_fault_pkg::st_active;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_cnt_ff <= 8'h00;
      rx_cnt_ff <= 8'h00;
      rec_ff    <= 4'h0;
      state_ff  <= can_fault_pkg::st_active;
    end else if (soft_rst) begin
      tx_cnt_ff <= 8'h00;
      rx_cnt_ff <= 8'h00;
      rec_ff    <= 4'h0;
      if (!cfg_ff[can_fault_pkg::CFG_LISTEN]) begin
        state_ff <= can_fault_pkg::st_active;
      end
    end else begin
      tx_cnt_ff <= nxt_tx_cnt;
      rx_cnt_ff <= nxt_rx_cnt;
      rec_ff    <= nxt_rec;
      state_ff  <= nxt_state;
    end
  end

  // error bits and summary flags
  always_ff @(posedge clk) begin
    if (rst) begin
      err_flags_ff <= '0;
    end else begin
      // read clears, new events still land
      err_flags_ff <= (esr_read ? '0 : err_flags_ff) | err_eff;
    end
  end

  assign tx_warning_status = tx_cnt_ff >= can_fault_pkg::WARN_LEVEL;
  assign rx_warning_status = rx_cnt_ff >= can_fault_pkg::WARN_LEVEL;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_warn_prev_ff <= 1'b0;
      rx_warn_prev_ff <= 1'b0;
    end else begin
      tx_warn_prev_ff <= tx_warning_status;
      rx_warn_prev_ff <= rx_warning_status;
    end
  end

  function automatic logic w1c(input logic cur, input logic set, input logic clr);
    return set || (cur && !clr);
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_warn_flag_ff <= 1'b0;
      rx_warn_flag_ff <= 1'b0;
      busoff_flag_ff  <= 1'b0;
      err_sum_flag_ff <= 1'b0;
    end else begin
      // rising warning sets, write one clears, set wins
      tx_warn_flag_ff <= w1c(tx_warn_flag_ff, cfg_ff[can_fault_pkg::CFG_WARNING_ENABLE] &&
                             tx_warning_status && !tx_warn_prev_ff,
                             wr_fire && s_axi_awaddr == can_fault_pkg::ADDR_ESR &&
                             wmask[can_fault_pkg::ESR_TWINT] &&
                             s_axi_wdata[can_fault_pkg::ESR_TWINT]);
      rx_warn_flag_ff <= w1c(rx_warn_flag_ff, cfg_ff[can_fault_pkg::CFG_WARNING_ENABLE] &&
                             rx_warning_status && !rx_warn_prev_ff,
                             wr_fire && s_axi_awaddr == can_fault_pkg::ADDR_ESR &&
                             wmask[can_fault_pkg::ESR_RWINT] &&
                             s_axi_wdata[can_fault_pkg::ESR_RWINT]);
      // bus-off entry and any error set the flags
      busoff_flag_ff  <= w1c(busoff_flag_ff, state_ff != can_fault_pkg::st_busoff &&
                             nxt_state == can_fault_pkg::st_busoff && !soft_rst,
                             wr_fire && s_axi_awaddr == can_fault_pkg::ADDR_ESR &&
                             wmask[can_fault_pkg::ESR_BOINT] &&
                             s_axi_wdata[can_fault_pkg::ESR_BOINT]);
      err_sum_flag_ff <= w1c(err_sum_flag_ff, |err_eff,
                             wr_fire && s_axi_awaddr == can_fault_pkg::ADDR_ESR &&
                             wmask[can_fault_pkg::ESR_ERINT] &&
                             s_axi_wdata[can_fault_pkg::ESR_ERINT]);
    end
  end

  // warning masks gated by the enable
  assign irq_tx_warning = tx_warn_flag_ff && cfg_ff[can_fault_pkg::CFG_TWMSK] &&
                          cfg_ff[can_fault_pkg::CFG_WARNING_ENABLE];
  assign irq_rx_warning = rx_warn_flag_ff && cfg_ff[can_fault_pkg::CFG_RWMSK] &&
                          cfg_ff[can_fault_pkg::CFG_WARNING_ENABLE];
  assign irq_bus_off    = busoff_flag_ff && cfg_ff[can_fault_pkg::CFG_BOMSK];
  assign irq_error      = err_sum_flag_ff && cfg_ff[can_fault_pkg::CFG_ERMSK];

  always_comb begin
    unique case (state_ff)
      can_fault_pkg::st_active:  flt_field = can_fault_pkg::FLT_ACTIVE;
      can_fault_pkg::st_passive: flt_field = can_fault_pkg::FLT_PASSIVE;
      default:                   flt_field = can_fault_pkg::FLT_BUSOFF;
    endcase
    if (cfg_ff[can_fault_pkg::CFG_LISTEN] && state_ff != can_fault_pkg::st_busoff) begin
      flt_field = can_fault_pkg::FLT_PASSIVE;
    end
    esr_value = 32'h00000000;
    esr_value[can_fault_pkg::ESR_TWINT] = tx_warn_flag_ff;
    esr_value[can_fault_pkg::ESR_RWINT] = rx_warn_flag_ff;
    esr_value[can_fault_pkg::ESR_ERR_HI:can_fault_pkg::ESR_ERR_LO] = err_flags_ff;
    esr_value[can_fault_pkg::ESR_TX_WARNING_STATUS] = tx_warning_status;
    esr_value[can_fault_pkg::ESR_RX_WARNING_STATUS] = rx_warning_status;
    esr_value[can_fault_pkg::ESR_IDLE] = bus_idle;
    esr_value[can_fault_pkg::ESR_DIR]  = transmitting && !bus_idle;
    esr_value[can_fault_pkg::ESR_FLT_HI:can_fault_pkg::ESR_FLT_LO] = flt_field;
    esr_value[can_fault_pkg::ESR_BOINT] = busoff_flag_ff;
    esr_value[can_fault_pkg::ESR_ERINT] = err_sum_flag_ff;
  end

  always_comb begin
    rd_value = 32'h00000000;
    unique case (s_axi_araddr)
      can_fault_pkg::ADDR_CONFIG: begin
        rd_value[can_fault_pkg::CFG_WIDTH-1:0] = cfg_ff;
        // warning masks read zero without the enable
        if (!cfg_ff[can_fault_pkg::CFG_WARNING_ENABLE]) begin
          rd_value[can_fault_pkg::CFG_TWMSK] = 1'b0;
          rd_value[can_fault_pkg::CFG_RWMSK] = 1'b0;
        end
      end
      can_fault_pkg::ADDR_GMASK:  rd_value = gmask_ff;
      can_fault_pkg::ADDR_MASK14: rd_value = mask14_ff;
      can_fault_pkg::ADDR_MASK15: rd_value = mask15_ff;
      can_fault_pkg::ADDR_IMASK2: rd_value = imask2_ff;
      can_fault_pkg::ADDR_ECR:    rd_value = {16'h0000, tx_cnt_ff, rx_cnt_ff};
      can_fault_pkg::ADDR_ESR:    rd_value = esr_value;
      default: ;
    endcase
  end
endmodule

// ---- can_fault_confinement_and_masks_properties.sv ----
// register bus handshake checker for the fault block
`timescale 1ns/1ps
module can_fault_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rwait; s_axi_rvalid && !s_axi_rready; endsequence
  property p_wans; s_axi_awready |=> s_axi_bvalid; endproperty
  a_wans: assert property (p_wans) else $error("no write answer");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write answer stuck");
  property p_wgap; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_wgap: assert property (p_wgap) else $error("write taken while answering");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("no read answer");
  property p_rhold; s_rwait |=> s_axi_rvalid; endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone) else $error("read answer stuck");
  property p_rgap; s_axi_arready != s_axi_rvalid; endproperty
  a_rgap: assert property (p_rgap) else $error("read ready wrong");
endmodule
bind can_fault_confinement_and_masks can_fault_props chk_u (.*);

// ---- can_bus_model.sv ----
// far-side bus: a bit time every four clocks, dominant on request
`timescale 1ns/1ps
module can_bus_model (
  input  wire logic clk,
  input  wire logic dom,
  output logic      bit_tick,
  output logic      rx_bit
);
  logic [1:0] div_ff = 2'h0;
  always @(posedge clk) div_ff <= div_ff + 2'h1;
  assign bit_tick = &div_ff;
  assign rx_bit = ~dom;
endmodule

// ---- can_fault_confinement_and_masks_tb.sv ----
// self-checking bench for the fault confinement and mask block
`timescale 1ns/1ps
module can_fault_confinement_and_masks_tb;
  logic clk = 0, rst = 1, dom = 1, bus_idle = 1, transmitting = 0, soft_rst = 0;
  logic filt_is_queue = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, filt_match_ff, bit_tick, rx_bit, irq_tx_warning;
  logic irq_rx_warning, irq_bus_off, irq_error;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [5:0] filt_index = 6'h0E;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 0, filt_word = 1, filt_rx_word = 0, filt_indiv_mask = 0, s_axi_rdata;
  can_fault_pkg::err_ev_type err_ev = '0;
  can_fault_pkg::cnt_ev_type cnt_ev = '0;
  can_fault_pkg::bit_ctx_type bit_ctx = '0;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  can_fault_confinement_and_masks dut_u (.*);
  can_bus_model bus_u (.clk, .dom, .bit_tick, .rx_bit);
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin n_mismatch++; stop_test(); end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
    @(posedge clk iff s_axi_awready);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    @(posedge clk iff s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    @(posedge clk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge clk iff s_axi_rvalid);
    chk(s_axi_rdata & m, e);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ev(input logic [4:0] c, input logic [5:0] e);
    {cnt_ev, err_ev} <= {c, e};
    @(posedge clk);
    {cnt_ev, err_ev} <= 11'h0;
    @(posedge clk);
  endtask
  task automatic fm(input logic e);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, filt_match_ff}, {31'h0, e});
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(8'h18, 32'hFFFFFFFF, 32'hFFFFFFFF);
    rc(8'h30, 32'hFFFFFFFF, 32'h0);
    rc(8'h20, 32'hF0, 32'h80);
    wr(8'h00, 32'h8);
    fm(1'b0);
    wr(8'h14, 32'hFFFFFFFE);
    fm(1'b1);
    filt_index <= 6'h0F;
    fm(1'b0);
    $display("test masks done");
    wr(8'h1C, 32'hFC00);
    repeat (6) @(posedge clk);
    rc(8'h1C, 32'hFFFF, 32'hFC00);
    rc(8'h20, 32'h30, 32'h10);
    wr(8'h00, 32'h80);
    ev(5'h10, 6'h0);
    rc(8'h1C, 32'hFFFF, 32'h0);
    rc(8'h20, 32'h34, 32'h24);
    chk({31'h0, irq_bus_off}, 32'h1);
    wr(8'h20, 32'h4);
    rc(8'h20, 32'h4, 32'h0);
    dom <= 1'b0;
    repeat (5800) @(posedge clk);
    rc(8'h20, 32'h30, 32'h0);
    rc(8'h1C, 32'hFFFF, 32'h0);
    $display("test counters done");
    bit_ctx <= 4'h8;
    wr(8'h00, 32'h100);
    for (int i = 0; i < 6; i++) begin
      ev(5'h0, 6'h1 << i);
      rc(8'h20, 32'hFC00, 32'h400 << i);
    end
    rc(8'h20, 32'hFC02, 32'h2);
    chk({31'h0, irq_error}, 32'h1);
    $display("test errors done");
    wr(8'h00, 32'h60);
    rc(8'h00, 32'h60, 32'h0);
    wr(8'h00, 32'h6C);
    rc(8'h00, 32'h6C, 32'h6C);
    for (int i = 0; i < 12; i++) ev(5'h04, 6'h0);
    rc(8'h20, 32'h10100, 32'h10100);
    chk({31'h0, irq_rx_warning}, 32'h1);
    for (int i = 0; i < 4; i++) ev(5'h04, 6'h0);
    rc(8'h20, 32'h30, 32'h10);
    ev(5'h04, 6'h08);
    rc(8'h1C, 32'hFFFF, 32'h0880);
    ev(5'h01, 6'h0);
    rc(8'h1C, 32'hFFFF, 32'h0877);
    rc(8'h20, 32'h30, 32'h0);
    wr(8'h00, 32'h6D);
    fm(1'b1);
    $display("test warnings done");
    stop_test();
  end
endmodule
